// *** src/bsc_slew_ctrl.sv ***
// Buck set-point and slew sequencer with its two control registers
//
// Contract
// - buck3 control register at 0x10, writes accepted only while unlocked.
// - bit 7 picks external adjust; then the register code is ignored.
// - six-bit code resets to 001000 and decodes to the voltage table.
// - shared slew and mode register at 0x11, writes accepted only while unlocked.
// - writing 1 to bit 7 starts transitions; writing 0 changes nothing.
// - trigger bit clears itself when the transition finishes.
// - with bit 6 set, any code write starts a transition without trigger.
// - automatic transitions still use the programmed step timing.
// - bits 5..3 force converters one to three into fixed-frequency mode.
// - slew code 000 is 224 us per step, halving per code.
// - slew code 111 applies the target immediately.
// - slew field resets to 110, 3.5 us per step.
// - one slew setting governs all three converters.
// - voltage slew follows code step size over step time.
module bsc_slew_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic reg_wr_unlock,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Stored codes of the other converters
    input wire logic [5:0] buck1_stored_code,
    input wire logic [5:0] buck2_stored_code,
    input wire logic buck1_code_wr,
    input wire logic buck2_code_wr,
    // Converter controls
    output logic [5:0] buck1_applied_code,
    output logic [5:0] buck2_applied_code,
    output logic [5:0] buck3_applied_code,
    output logic [11:0] buck3_setpoint_mv,
    output logic buck3_external_adjust_sel,
    output logic buck1_force_fixed_freq,
    output logic buck2_force_fixed_freq,
    output logic buck3_force_fixed_freq,
    output logic transition_busy
);
    import bsc_pkg::*;

    logic [7:0] buck3_ctrl_r;
    logic [6:0] slew_lo_r;
    logic go_r;
    logic go_nxt;
    logic pend_r;
    logic init_r;
    logic busy_r;
    logic [7:0] rdata_r;
    logic [11:0] mv_r;
    bsc_state_type state_r;
    bsc_state_type state_nxt;
    logic [5:0] applied_r [BSC_NUM_BUCK];
    logic [5:0] applied_nxt [BSC_NUM_BUCK];
    logic [5:0] tgt_r [BSC_NUM_BUCK];
    logic [5:0] stored [BSC_NUM_BUCK];
    logic [BSC_NUM_BUCK-1:0] at_tgt;
    wire logic wr_ok;
    wire logic wr_buck3;
    wire logic wr_slew;
    wire logic go_write;
    wire logic code_write;
    wire logic start;
    wire logic running;
    wire logic finish;
    wire logic immediate;
    wire logic step;
    wire logic [2:0] slew_code;
    wire logic bypass;
    wire logic [7:0] slew_view;
    wire logic [7:0] rdata_nxt;

    // Register decode, writes gated by unlock
    assign wr_ok = reg_wr_en && reg_wr_unlock;
    assign wr_buck3 = wr_ok && (reg_addr == BSC_BUCK3_CTRL_OFS);
    assign wr_slew = wr_ok && (reg_addr == BSC_SLEW_CTRL_OFS);
    assign slew_code = slew_lo_r[BSC_SLEW_MSB:0];
    assign bypass = slew_lo_r[BSC_BYPASS_BIT];
    assign slew_view = {go_r, slew_lo_r};

    // Start sources: trigger write, or any code write while bypassed
    assign go_write = wr_slew && reg_wdata[BSC_GO_BIT];
    assign code_write = wr_buck3 || buck1_code_wr || buck2_code_wr;
    assign start = go_write || (bypass && code_write);
    assign running = (state_r == BSC_ST_RUN) && !pend_r;
    assign finish = running && (&at_tgt);
    assign immediate = (slew_code == BSC_SLEW_IMMEDIATE);

    // Trigger bit: new trigger beats the self-clear
    assign go_nxt = go_write ? 1'b1 : (finish ? 1'b0 : go_r);

    // Read mux, unmapped reads return zero
    assign rdata_nxt = (reg_addr == BSC_BUCK3_CTRL_OFS) ? buck3_ctrl_r :
                       (reg_addr == BSC_SLEW_CTRL_OFS) ? slew_view : 8'h00;

    // Per-converter sources
    assign stored[0] = buck1_stored_code;
    assign stored[1] = buck2_stored_code;
    assign stored[2] = buck3_ctrl_r[BSC_CODE_MSB:0];

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BSC_ST_IDLE: begin
                if (pend_r) begin
                    state_nxt = BSC_ST_RUN;
                end
            end
            BSC_ST_RUN: begin
                if (finish) begin
                    state_nxt = BSC_ST_IDLE;
                end
            end
            default: state_nxt = BSC_ST_IDLE;
        endcase
    end

    // Shared step timer for all converters
    bsc_step_timer u_step_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(running && !immediate),
        .slew_code(slew_code),
        .step(step)
    );

    // Per-converter walk toward target
    generate
        for (genvar i = 0; i < BSC_NUM_BUCK; i++) begin : g_buck
            assign at_tgt[i] = (applied_r[i] == tgt_r[i]);
            assign applied_nxt[i] = init_r ? stored[i] :
                                    (running && immediate) ? tgt_r[i] :
                                    (running && step) ? bsc_step_toward(applied_r[i], tgt_r[i]) :
                                    applied_r[i];

            // Applied code and latched target
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    applied_r[i] <= BSC_BUCK3_CTRL_RST[BSC_CODE_MSB:0];
                    tgt_r[i] <= BSC_BUCK3_CTRL_RST[BSC_CODE_MSB:0];
                end else begin
                    applied_r[i] <= applied_nxt[i];
                    if (init_r) begin
                        tgt_r[i] <= stored[i];
                    end else if (pend_r) begin
                        // External adjust freezes buck3 at its present code
                        tgt_r[i] <= (i == 2 && buck3_ctrl_r[BSC_EXT_ADJ_BIT]) ? applied_r[i] : stored[i];
                    end
                end
            end
        end
    endgenerate

    // Register storage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            buck3_ctrl_r <= BSC_BUCK3_CTRL_RST;
            slew_lo_r <= BSC_SLEW_CTRL_RST[6:0];
            go_r <= 1'b0;
        end else begin
            if (wr_buck3) begin
                buck3_ctrl_r <= reg_wdata;
            end
            if (wr_slew) begin
                slew_lo_r <= reg_wdata[6:0];
            end
            go_r <= go_nxt;
        end
    end

    // Sequencer and output registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= BSC_ST_IDLE;
            pend_r <= 1'b0;
            init_r <= 1'b1;
            busy_r <= 1'b0;
            rdata_r <= 8'h00;
            mv_r <= 12'h000;
        end else begin
            state_r <= state_nxt;
            pend_r <= start;
            init_r <= 1'b0;
            busy_r <= (state_nxt == BSC_ST_RUN) || start;
            if (reg_rd_en) begin
                rdata_r <= rdata_nxt;
            end
            mv_r <= bsc_code_to_mv(applied_nxt[2]);
        end
    end

    // Outputs straight from flops
    assign reg_rdata = rdata_r;
    assign buck1_applied_code = applied_r[0];
    assign buck2_applied_code = applied_r[1];
    assign buck3_applied_code = applied_r[2];
    assign buck3_setpoint_mv = mv_r;
    assign buck3_external_adjust_sel = buck3_ctrl_r[BSC_EXT_ADJ_BIT];
    assign buck1_force_fixed_freq = slew_lo_r[BSC_FF1_BIT];
    assign buck2_force_fixed_freq = slew_lo_r[BSC_FF2_BIT];
    assign buck3_force_fixed_freq = slew_lo_r[BSC_FF3_BIT];
    assign transition_busy = busy_r;

    // Checks
    sequence bypass_write_s;
        bypass && wr_buck3 && !go_write;
    endsequence
    sequence run_entered_s;
        pend_r ##1 (state_r == BSC_ST_RUN);
    endsequence
    sequence jump_s;
        running && immediate;
    endsequence

    property locked_ctrl_p;
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_wr_en && !reg_wr_unlock) |=> $stable(buck3_ctrl_r) && $stable(slew_lo_r);
    endproperty
    locked_write_a: assert property (locked_ctrl_p) else $error("locked write changed a register");

    buck3_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_buck3 |=> buck3_ctrl_r == $past(reg_wdata)) else $error("buck3 write lost");

    ext_adjust_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pend_r && buck3_ctrl_r[BSC_EXT_ADJ_BIT] && !init_r) |=> tgt_r[2] == $past(applied_r[2]))
        else $error("external adjust did not freeze buck3");

    slew_ff_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_slew |=> buck3_force_fixed_freq == $past(reg_wdata[BSC_FF3_BIT]))
        else $error("fixed frequency bit not stored");

    go_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_slew && !reg_wdata[BSC_GO_BIT] && !go_r) |=> !go_r && !pend_r)
        else $error("zero trigger write acted");

    go_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (finish && !go_write) |=> !go_r && state_r == BSC_ST_IDLE)
        else $error("trigger not cleared at finish");

    bypass_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bypass_write_s |=> run_entered_s) else $error("bypass write did not start");

    no_bypass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!bypass && code_write && !go_write) |=> !pend_r) else $error("code write started without trigger");

    hold_between_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && !step && !immediate && !init_r) |=> applied_r[0] == $past(applied_r[0]))
        else $error("code moved without a step");

    one_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && step && !immediate && applied_r[2] < tgt_r[2]) |=> applied_r[2] == $past(applied_r[2]) + 6'h01)
        else $error("code did not move by one");

    immediate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && immediate) |=> applied_r[1] == $past(tgt_r[1]))
        else $error("immediate slew did not jump");

    go_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        go_write |=> go_r)
        else $error("trigger bit not set");

    go_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        go_write |=> run_entered_s)
        else $error("trigger write did not start");

    go_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        go_r |-> busy_r)
        else $error("trigger bit set while not busy");

    slew_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_slew |=> slew_lo_r == $past(reg_wdata[6:0]))
        else $error("slew register write lost");

    ff_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_slew |=> buck1_force_fixed_freq == $past(reg_wdata[BSC_FF1_BIT])
            && buck2_force_fixed_freq == $past(reg_wdata[BSC_FF2_BIT]))
        else $error("fixed frequency bits one and two not stored");

    hold_all_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && !step && !immediate && !init_r) |=> $stable(applied_r[1]) && $stable(applied_r[2]))
        else $error("converter moved off the shared step");

    step_down_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && step && !immediate && applied_r[1] > tgt_r[1]) |=> applied_r[1] == $past(applied_r[1]) - 6'h01)
        else $error("code did not move down by one");

    idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_r == BSC_ST_IDLE && !pend_r && !init_r) |=> $stable(applied_r[0]) && $stable(applied_r[1]) && $stable(applied_r[2]))
        else $error("code moved outside a transition");

    mv_track_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !init_r |-> mv_r == bsc_code_to_mv(applied_r[2]))
        else $error("millivolt output does not match applied code");

    jump_done_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        jump_s |=> (&at_tgt))
        else $error("immediate slew left a converter short");

endmodule : bsc_slew_ctrl

// *** src/bsc_pkg.sv ***
// Package: register map, field layout, timing and decode helpers for the buck slew block
package bsc_pkg;

    // Register offsets and reset values
    localparam logic [7:0] BSC_BUCK3_CTRL_OFS = 8'h10;
    localparam logic [7:0] BSC_SLEW_CTRL_OFS = 8'h11;
    localparam logic [7:0] BSC_BUCK3_CTRL_RST = 8'h08;
    localparam logic [7:0] BSC_SLEW_CTRL_RST = 8'h06;

    // Field positions
    localparam int BSC_EXT_ADJ_BIT = 7;
    localparam int BSC_GO_BIT = 7;
    localparam int BSC_BYPASS_BIT = 6;
    localparam int BSC_FF1_BIT = 5;
    localparam int BSC_FF2_BIT = 4;
    localparam int BSC_FF3_BIT = 3;
    localparam int BSC_SLEW_MSB = 2;
    localparam int BSC_CODE_MSB = 5;
    localparam int BSC_NUM_BUCK = 3;

    // Slew code that skips the step timer
    localparam logic [2:0] BSC_SLEW_IMMEDIATE = 3'h7;

    // Step timing at the 10 MHz reference clock
    localparam int BSC_CLK_PERIOD_NS = 100;
    localparam int BSC_STEP_TIME_BASE_NS = 224000;
    localparam int BSC_STEP_TIME_MIN_NS = 3500;
    localparam logic [11:0] BSC_STEP_CYCLES_BASE =
        12'((BSC_STEP_TIME_BASE_NS + BSC_CLK_PERIOD_NS - 1) / BSC_CLK_PERIOD_NS);
    localparam logic [11:0] BSC_STEP_CYCLES_MIN =
        12'((BSC_STEP_TIME_MIN_NS + BSC_CLK_PERIOD_NS - 1) / BSC_CLK_PERIOD_NS);

    // Sequencer states
    typedef enum logic [1:0] {
        BSC_ST_IDLE = 2'b01,
        BSC_ST_RUN = 2'b10
    } bsc_state_type;

    // Set-point code to millivolts
    function automatic logic [11:0] bsc_code_to_mv(input logic [5:0] code);
        logic [11:0] n;
        logic [11:0] mv;
        n = {8'h00, code[3:0]};
        mv = 12'h384;
        case (code[5:4])
            2'h0: mv = 12'h384 + 12'(12'h019 * n);              // 900 mV + 25 mV/code
            2'h1: begin
                if (n < 12'h008) begin
                    mv = 12'h514 + 12'(12'h019 * n);            // 1300 mV + 25 mV/code
                end else begin
                    mv = 12'h5DC + 12'(12'h032 * (n - 12'h008)); // 1500 mV + 50 mV/code
                end
            end
            2'h2: mv = 12'h76C + 12'(12'h032 * n);              // 1900 mV + 50 mV/code
            2'h3: begin
                if (n < 12'h004) begin
                    mv = 12'hA8C + 12'(12'h032 * n);            // 2700 mV + 50 mV/code
                end else if (n < 12'h008) begin
                    mv = 12'hB54 + 12'(12'h064 * (n - 12'h004)); // 2900 mV + 100 mV/code
                end else begin
                    mv = 12'hCE4;                               // 3300 mV ceiling
                end
            end
            default: mv = 12'h384;
        endcase
        return mv;
    endfunction : bsc_code_to_mv

    // One code toward the target
    function automatic logic [5:0] bsc_step_toward(input logic [5:0] cur, input logic [5:0] tgt);
        logic [5:0] res;
        res = cur;
        if (cur < tgt) begin
            res = 6'(cur + 6'h01);
        end else if (cur > tgt) begin
            res = 6'(cur - 6'h01);
        end
        return res;
    endfunction : bsc_step_toward

endpackage : bsc_pkg

// *** src/bsc_step_timer.sv ***
// Step interval timer: one pulse per programmed slew step while running
module bsc_step_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [2:0] slew_code,
    // Step pulse
    output logic step
);
    import bsc_pkg::*;

    logic [11:0] cnt_r;
    logic [11:0] cnt_nxt;
    logic step_r;
    wire logic [11:0] load_val;
    wire logic expire;

    // Interval halves with each higher code
    assign load_val = 12'(BSC_STEP_CYCLES_BASE >> slew_code);
    assign expire = run && (cnt_r == 12'h001);
    assign cnt_nxt = (!run || expire) ? load_val : 12'(cnt_r - 12'h001);
    assign step = step_r;

    // Counter and pulse register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= BSC_STEP_CYCLES_MIN;
            step_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            step_r <= expire;
        end
    end

    // Fastest timed code keeps at least eight step-free cycles after each step
    property fast_spacing_p;
        @(posedge ref_clk) disable iff (!rst_n)
        (step_r && run && slew_code == 3'h6 && $stable(slew_code)) |=> (!step_r) [*8];
    endproperty
    step_spacing_a: assert property (fast_spacing_p) else $error("step pulses too close");

endmodule : bsc_step_timer

// *** bench/bsc_host_model.sv ***
// Host model: drives the block's register port one byte at a time
module bsc_host_model (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic reg_wr_unlock,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idle at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wr_unlock = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // Single write; unlock low models a write without the password
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic unl);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_wr_unlock <= unl;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        reg_wr_unlock <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr

    // Single read; data is taken once the registered answer has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        @(posedge ref_clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : bsc_host_model

// *** bench/buck_setpoint_slew_ctrl_test.sv ***
// Self-checking bench for the buck set-point and slew sequencer
module buck_setpoint_slew_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import bsc_pkg::*;

    // Stimulus and observed signals
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en, reg_rd_en, reg_wr_unlock;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
    logic [5:0] buck1_stored_code = 6'h08;
    logic [5:0] buck2_stored_code = 6'h08;
    logic buck1_code_wr = 1'b0;
    logic buck2_code_wr = 1'b0;
    logic [5:0] buck1_applied_code, buck2_applied_code, buck3_applied_code, c3;
    logic [11:0] buck3_setpoint_mv;
    logic buck3_external_adjust_sel, buck1_force_fixed_freq, buck2_force_fixed_freq, buck3_force_fixed_freq;
    logic transition_busy;
    logic [17:0] codes;
    logic [2:0] ff;
    int n_errors = 0;
    int n_compared = 0;

    // Grouped views of the outputs
    assign codes = {buck1_applied_code, buck2_applied_code, buck3_applied_code};
    assign ff = {buck1_force_fixed_freq, buck2_force_fixed_freq, buck3_force_fixed_freq};

    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    // Host on the register port
    bsc_host_model host (.ref_clk, .reg_wr_en, .reg_rd_en, .reg_wr_unlock, .reg_addr, .reg_wdata, .reg_rdata);

    // Block under test
    bsc_slew_ctrl DUT (.ref_clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_wr_unlock, .reg_addr, .reg_wdata,
        .reg_rdata, .buck1_stored_code, .buck2_stored_code, .buck1_code_wr, .buck2_code_wr,
        .buck1_applied_code, .buck2_applied_code, .buck3_applied_code, .buck3_setpoint_mv,
        .buck3_external_adjust_sel, .buck1_force_fixed_freq, .buck2_force_fixed_freq,
        .buck3_force_fixed_freq, .transition_busy);

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Wait cycles, then step past the edge so outputs are settled
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wt

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rd_v);
        chk(rd_v, exp);
    endtask : rchk

    // Bounded wait for the end of a transition
    task automatic idle();
        int i;
        i = 0;
        wt(2);
        while (transition_busy !== 1'b0 && i < 3000) begin
            wt(1);
            i++;
        end
        chk(transition_busy, 1'b0);
    endtask : idle

    task automatic close_out();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // Watchdog well beyond the longest expected run
    initial begin
        wt(30000);
        n_errors++;
        close_out();
    end

    // Test sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        wt(2);
        rchk(BSC_BUCK3_CTRL_OFS, 8'h08);
        rchk(BSC_SLEW_CTRL_OFS, 8'h06);
        rchk(8'h12, 8'h00);
        chk(buck3_setpoint_mv, 12'h44C);
        // Writes without the password are dropped
        host.wr(8'h10, 8'h0A, 1'b0);
        host.wr(8'h11, 8'h3F, 1'b0);
        rchk(8'h10, 8'h08);
        rchk(8'h11, 8'h06);
        // Stored code waits for the trigger, then all three walk one code per step
        host.wr(8'h10, 8'h4A, 1'b1);
        rchk(8'h10, 8'h4A);
        @(posedge ref_clk);
        buck1_stored_code <= 6'h0A;
        buck2_stored_code <= 6'h06;
        wt(40);
        chk(buck3_applied_code, 6'h08);
        host.wr(8'h11, 8'h86, 1'b1);
        wt(30);
        chk(codes, {6'h08, 6'h08, 6'h08});
        wt(10);
        chk(codes, {6'h09, 6'h07, 6'h09});
        rchk(8'h11, 8'h86);
        idle();
        chk(codes, {6'h0A, 6'h06, 6'h0A});
        rchk(8'h11, 8'h06);
        chk(buck3_setpoint_mv, 12'h47E);
        // Writing zero to the trigger starts nothing
        host.wr(8'h10, 8'h0C, 1'b1);
        host.wr(8'h11, 8'h06, 1'b1);
        wt(100);
        chk({transition_busy, codes}, {1'b0, 6'h0A, 6'h06, 6'h0A});
        // Immediate slew code
        host.wr(8'h11, 8'h87, 1'b1);
        wt(5);
        chk(buck3_applied_code, 6'h0C);
        idle();
        chk(buck3_setpoint_mv, 12'h4B0);
        // Trigger bypass: code writes start stepped transitions
        host.wr(8'h11, 8'h46, 1'b1);
        host.wr(8'h10, 8'h0E, 1'b1);
        wt(20);
        chk(buck3_applied_code, 6'h0C);
        idle();
        @(posedge ref_clk);
        buck1_stored_code <= 6'h0B;
        buck2_stored_code <= 6'h05;
        buck1_code_wr <= 1'b1;
        buck2_code_wr <= 1'b1;
        @(posedge ref_clk);
        buck1_code_wr <= 1'b0;
        buck2_code_wr <= 1'b0;
        idle();
        chk(codes, {6'h0B, 6'h05, 6'h0E});
        // Step time of every timed slew code, 000 to 110, one step each
        host.wr(8'h11, 8'h06, 1'b1);
        c3 = 6'h0E;
        for (int k = 0; k < 7; k++) begin
            c3++;
            host.wr(8'h10, {2'b00, c3}, 1'b1);
            host.wr(8'h11, 8'h80 | 8'(k), 1'b1);
            wt((2240 >> k) - 5);
            chk(buck3_applied_code, c3 - 6'h01);
            wt(10);
            chk(buck3_applied_code, c3);
            idle();
        end
        chk(buck3_setpoint_mv, 12'h591);
        // Forced fixed-frequency bits, one converter at a time
        for (int i = 0; i < 3; i++) begin
            host.wr(8'h11, 8'h20 >> i, 1'b1);
            wt(2);
            chk(ff, 3'b100 >> i);
        end
        rchk(8'h11, 8'h08);
        // External adjust keeps the present code
        host.wr(8'h10, 8'hB8, 1'b1);
        host.wr(8'h11, 8'h87, 1'b1);
        idle();
        chk({buck3_external_adjust_sel, buck3_applied_code}, {1'b1, 6'h15});
        // Top code 111111 decodes to the ceiling
        host.wr(8'h10, 8'h3F, 1'b1);
        host.wr(8'h11, 8'h87, 1'b1);
        idle();
        chk(buck3_setpoint_mv, 12'hCE4);
        chk(buck3_external_adjust_sel, 1'b0);
        close_out();
    end
endmodule : buck_setpoint_slew_ctrl_test
